// ---- src/asrc_lmc_cfg.svh ----
// Register indices, field positions, reset values and ramp counts for the converter lock/mute block
`ifndef ASRC_LMC_CFG_SVH
`define ASRC_LMC_CFG_SVH

// Register indices; byte address is four times the index
`define ASRC_IDX_GRP_A_LOCK_MUTE 16'hE101
`define ASRC_IDX_GRP_A_RAMP_DIS 16'hE103
`define ASRC_IDX_GRP_B_LOCK_MUTE 16'hE141
`define ASRC_IDX_GRP_B_RAMP_DIS 16'hE143
`define ASRC_IDX_IRQ_STATUS 16'hE104
`define ASRC_IDX_IRQ_MASK 16'hE105

// Field positions
`define ASRC_MUTE_LSB 0
`define ASRC_LOCK_LSB 8
`define ASRC_RAMP_DIS_BIT 0

// Reset values
`define ASRC_RST_MUTE 4'h0
`define ASRC_RST_RAMP_DIS 1'h0
`define ASRC_RST_IRQ 8'h00

// Output rate selector code meaning no rate
`define ASRC_RATE_NONE 6'h3F

// Ramp length in output samples; gain runs 0 .. full scale
`define ASRC_RAMP_STEPS 6'h20

`endif

// ---- src/asrc_lmc_pkg.sv ----
// Types shared by the converter lock/mute control block
package asrc_lmc_pkg;
   typedef enum logic [1:0] {
      RAMP_UNITY = 2'b00,
      RAMP_FALLING = 2'b01,
      RAMP_SILENT = 2'b10,
      RAMP_RISING = 2'b11
   } ramp_state_t;
   typedef logic [5:0] gain_t;
endpackage

// ---- src/asrc_mute_ramp.sv ----
// Per-pair mute volume ramp: gain steps one count per output sample, or jumps when abrupt
`timescale 1ns/1ps
`include "asrc_lmc_cfg.svh"
`default_nettype none
module asrc_mute_ramp (
   input wire logic clk, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic sampleTick, // One pulse per output sample of this pair
   input wire logic muteReq, // Mute wanted
   input wire logic abrupt, // Ramp disabled: jump straight to target
   output asrc_lmc_pkg::gain_t gain, // Current gain, full scale is unity
   output logic muted // Gain has reached zero
);
   asrc_lmc_pkg::ramp_state_t state_q;
   asrc_lmc_pkg::gain_t gain_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= asrc_lmc_pkg::RAMP_UNITY;
         gain_q <= `ASRC_RAMP_STEPS;
      end else begin
         case (state_q)
            asrc_lmc_pkg::RAMP_UNITY: begin
               if (muteReq && abrupt) begin
                  gain_q <= 6'h00;
                  state_q <= asrc_lmc_pkg::RAMP_SILENT;
               end else if (muteReq) begin
                  state_q <= asrc_lmc_pkg::RAMP_FALLING;
               end
            end
            asrc_lmc_pkg::RAMP_FALLING: begin
               if (!muteReq) begin
                  state_q <= asrc_lmc_pkg::RAMP_RISING;
               end else if (abrupt) begin
                  gain_q <= 6'h00;
                  state_q <= asrc_lmc_pkg::RAMP_SILENT;
               end else if (gain_q == 6'h00) begin
                  // Reversed before any step up: already at zero, never wrap
                  state_q <= asrc_lmc_pkg::RAMP_SILENT;
               end else if (sampleTick) begin
                  gain_q <= gain_q - 6'h01;
                  if (gain_q == 6'h01) begin
                     state_q <= asrc_lmc_pkg::RAMP_SILENT;
                  end
               end
            end
            asrc_lmc_pkg::RAMP_SILENT: begin
               if (!muteReq && abrupt) begin
                  gain_q <= `ASRC_RAMP_STEPS;
                  state_q <= asrc_lmc_pkg::RAMP_UNITY;
               end else if (!muteReq) begin
                  state_q <= asrc_lmc_pkg::RAMP_RISING;
               end
            end
            asrc_lmc_pkg::RAMP_RISING: begin
               if (muteReq) begin
                  state_q <= asrc_lmc_pkg::RAMP_FALLING;
               end else if (abrupt) begin
                  gain_q <= `ASRC_RAMP_STEPS;
                  state_q <= asrc_lmc_pkg::RAMP_UNITY;
               end else if (gain_q == `ASRC_RAMP_STEPS) begin
                  // Reversed before any step down: already at unity, never overshoot
                  state_q <= asrc_lmc_pkg::RAMP_UNITY;
               end else if (sampleTick) begin
                  gain_q <= gain_q + 6'h01;
                  if (gain_q == `ASRC_RAMP_STEPS - 6'h01) begin
                     state_q <= asrc_lmc_pkg::RAMP_UNITY;
                  end
               end
            end
            default: begin
               gain_q <= `ASRC_RAMP_STEPS;
               state_q <= asrc_lmc_pkg::RAMP_UNITY;
            end
         endcase
      end
   end

   assign gain = gain_q;
   assign muted = (gain_q == 6'h00);

   a_gain_step_down: assert property (@(posedge clk) disable iff (reset)
      (state_q == asrc_lmc_pkg::RAMP_FALLING && muteReq && !abrupt && sampleTick && gain_q != 6'h00)
      |=> gain_q == $past(gain_q) - 6'h01)
      else $error("ramp did not step gain down by one");

   a_gain_step_up: assert property (@(posedge clk) disable iff (reset)
      (state_q == asrc_lmc_pkg::RAMP_RISING && !muteReq && !abrupt && sampleTick && gain_q != `ASRC_RAMP_STEPS)
      |=> gain_q == $past(gain_q) + 6'h01)
      else $error("ramp did not step gain up by one");

   a_gain_in_range: assert property (@(posedge clk) disable iff (reset)
      gain_q <= `ASRC_RAMP_STEPS)
      else $error("gain left the ramp range");

   a_abrupt_jump: assert property (@(posedge clk) disable iff (reset)
      (muteReq && abrupt) ##1 (muteReq && abrupt) |=> gain_q == 6'h00)
      else $error("abrupt mute did not reach zero gain");
endmodule
`default_nettype wire

// ---- src/asrc_lock_mute_control.sv ----
// APB register block, lock flags, mute control and interrupts for eight stereo rate converters
//
// Contract
// - Converters talk only via the routing matrix
// - Mute bits 3:0: one mutes, zero unmutes
// - Ramped mute avoids clicks and pops
// - Group A: lock 11:8, mute 3:0
// - Group B: lock 11:8 for pairs 7:4
// - Reset clears lock, mute, ramp-disable bits
// - Clock enable sets lock flag, mutes
// - Rate chosen and locked clears lock flag
// - Cleared lock flag stays clear until reset
// - Group A ramp-disable bit 0 selects abrupt
// - Ramp disabled: ignore mute bits, mute on unlock
// - Without converters, writes have no effect; the code still applies IRQ status and mask writes
// - Rate code all ones means no rate
// - Group B ramp-disable bit 0, same behaviour
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "asrc_lmc_cfg.svh"
`default_nettype none
module asrc_lock_mute_control (
   input wire logic clk, // System clock, 20 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [17:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic convPresent, // High when converters are built in
   input wire logic [7:0] mclkEnable, // Master clock enable per pair
   input wire logic [7:0] outClockLocked, // Pair has locked to its output clock
   input wire logic [47:0] outRateSel, // Six-bit output rate code per pair
   input wire logic [7:0] sampleTick, // Output sample strobe per pair
   output logic [47:0] pairGain, // Gain per pair toward the routing matrix
   output logic [7:0] pairMuted, // Pair fully muted
   output logic [7:0] lockFlags, // Lock flags, one from first clock enable until locked
   output logic irq // Level interrupt
);
   logic [7:0] muteBits_q;
   logic [1:0] rampDis_q;
   logic [7:0] irqStat_q;
   logic [7:0] irqMask_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] lockFlag_q;
   logic [7:0] acquired_q;
   logic [7:0] mclkPrev_q;
   logic [7:0] lockEvent;
   logic [7:0] muteReq;
   logic [15:0] regIdx;
   logic setupPhase;
   logic wrAccess;
   logic [31:0] rdData;
   logic addrHit;

   assign regIdx = paddr[17:2];
   assign setupPhase = psel && !penable;
   // Absent converters make mute and ramp-disable writes a no-op; IRQ status and mask writes and reads still act
   assign wrAccess = psel && penable && pwrite && convPresent;
   assign pready = psel && penable;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign lockFlags = lockFlag_q;

   always_comb begin
      rdData = 32'h0000_0000;
      addrHit = 1'b1;
      case (regIdx)
         `ASRC_IDX_GRP_A_LOCK_MUTE: begin
            rdData[`ASRC_LOCK_LSB +: 4] = lockFlag_q[3:0];
            rdData[`ASRC_MUTE_LSB +: 4] = muteBits_q[3:0];
         end
         `ASRC_IDX_GRP_B_LOCK_MUTE: begin
            rdData[`ASRC_LOCK_LSB +: 4] = lockFlag_q[7:4];
            rdData[`ASRC_MUTE_LSB +: 4] = muteBits_q[7:4];
         end
         `ASRC_IDX_GRP_A_RAMP_DIS: begin
            rdData[`ASRC_RAMP_DIS_BIT] = rampDis_q[0];
         end
         `ASRC_IDX_GRP_B_RAMP_DIS: begin
            rdData[`ASRC_RAMP_DIS_BIT] = rampDis_q[1];
         end
         `ASRC_IDX_IRQ_STATUS: begin
            rdData[7:0] = irqStat_q;
         end
         `ASRC_IDX_IRQ_MASK: begin
            rdData[7:0] = irqMask_q;
         end
         default: begin
            addrHit = 1'b0;
         end
      endcase
   end

   // Read data and error are captured in the setup cycle so they leave flops
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setupPhase) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rdData;
         pslverr_q <= !addrHit;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         muteBits_q <= {`ASRC_RST_MUTE, `ASRC_RST_MUTE};
      end else if (wrAccess && regIdx == `ASRC_IDX_GRP_A_LOCK_MUTE) begin
         muteBits_q[3:0] <= pwdata[`ASRC_MUTE_LSB +: 4];
      end else if (wrAccess && regIdx == `ASRC_IDX_GRP_B_LOCK_MUTE) begin
         muteBits_q[7:4] <= pwdata[`ASRC_MUTE_LSB +: 4];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rampDis_q <= {`ASRC_RST_RAMP_DIS, `ASRC_RST_RAMP_DIS};
      end else if (wrAccess && regIdx == `ASRC_IDX_GRP_A_RAMP_DIS) begin
         rampDis_q[0] <= pwdata[`ASRC_RAMP_DIS_BIT];
      end else if (wrAccess && regIdx == `ASRC_IDX_GRP_B_RAMP_DIS) begin
         rampDis_q[1] <= pwdata[`ASRC_RAMP_DIS_BIT];
      end
   end

   // A lock event in the clearing cycle survives: set wins over clear
   always_ff @(posedge clk) begin
      if (reset) begin
         irqStat_q <= `ASRC_RST_IRQ;
      end else if (psel && penable && pwrite && regIdx == `ASRC_IDX_IRQ_STATUS) begin
         irqStat_q <= (irqStat_q & ~pwdata[7:0]) | lockEvent;
      end else begin
         irqStat_q <= irqStat_q | lockEvent;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irqMask_q <= `ASRC_RST_IRQ;
      end else if (psel && penable && pwrite && regIdx == `ASRC_IDX_IRQ_MASK) begin
         irqMask_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irqStat_q & irqMask_q);
      end
   end

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pair
         logic rateValid;
         logic lockDone;
         logic rampOff;
         asrc_lmc_pkg::gain_t gainVal;

         assign rateValid = outRateSel[6 * i +: 6] != `ASRC_RATE_NONE;
         assign lockDone = lockFlag_q[i] && rateValid && outClockLocked[i];
         assign lockEvent[i] = lockDone;
         assign rampOff = rampDis_q[i / 4];
         // Unlocked pairs always mute; mute bits count only while ramping
         assign muteReq[i] = lockFlag_q[i] || (muteBits_q[i] && !rampOff);

         always_ff @(posedge clk) begin
            if (reset) begin
               lockFlag_q[i] <= 1'b0;
               acquired_q[i] <= 1'b0;
               mclkPrev_q[i] <= 1'b0;
            end else begin
               mclkPrev_q[i] <= mclkEnable[i];
               if (lockDone) begin
                  lockFlag_q[i] <= 1'b0;
                  acquired_q[i] <= 1'b1;
               end else if (!acquired_q[i] && mclkEnable[i] && !mclkPrev_q[i]) begin
                  lockFlag_q[i] <= 1'b1;
               end
            end
         end

         asrc_mute_ramp u_ramp (
            .clk(clk),
            .reset(reset),
            .sampleTick(sampleTick[i]),
            .muteReq(muteReq[i]),
            .abrupt(rampOff),
            .gain(gainVal),
            .muted(pairMuted[i])
         );

         // Gain leaves only toward the routing matrix
         assign pairGain[6 * i +: 6] = gainVal;

         a_lock_set_enable: assert property (@(posedge clk) disable iff (reset)
            (!acquired_q[i] && $rose(mclkEnable[i]) && !lockDone) |=> lockFlag_q[i] && muteReq[i])
            else $error("clock enable did not raise lock flag");

         a_lock_clears: assert property (@(posedge clk) disable iff (reset)
            (lockFlag_q[i] && rateValid && outClockLocked[i]) |=> !lockFlag_q[i] ##1 !lockFlag_q[i])
            else $error("lock flag did not clear on lock");

         a_lock_stays_clear: assert property (@(posedge clk) disable iff (reset)
            acquired_q[i] |-> !lockFlag_q[i])
            else $error("cleared lock flag came back");

         a_no_rate_no_lock: assert property (@(posedge clk) disable iff (reset)
            (lockFlag_q[i] && !rateValid) |=> lockFlag_q[i])
            else $error("lock flag cleared without a rate");

         a_unlock_mutes: assert property (@(posedge clk) disable iff (reset)
            lockFlag_q[i] |-> muteReq[i])
            else $error("unlocked pair not muted");

         // Abrupt mode must drop the software mute, or the pair would sit silent
         a_ramp_off_unmuted: assert property (@(posedge clk) disable iff (reset)
            (rampOff && !lockFlag_q[i]) |-> !muteReq[i])
            else $error("mute bit honoured with ramp disabled");

         a_flag_rise_cause: assert property (@(posedge clk) disable iff (reset)
            $rose(lockFlag_q[i]) |-> !$past(acquired_q[i]) && $past(mclkEnable[i]) && !$past(mclkPrev_q[i]))
            else $error("lock flag rose without a first clock enable");
      end
   endgenerate

   sequence s_write_grp_a;
      psel && penable && pwrite && convPresent && regIdx == `ASRC_IDX_GRP_A_LOCK_MUTE;
   endsequence

   sequence s_read_setup_grp_a;
      psel && !penable && !pwrite && regIdx == `ASRC_IDX_GRP_A_LOCK_MUTE;
   endsequence

   sequence s_write_grp_b;
      psel && penable && pwrite && convPresent && regIdx == `ASRC_IDX_GRP_B_LOCK_MUTE;
   endsequence

   sequence s_read_setup_grp_b;
      psel && !penable && !pwrite && regIdx == `ASRC_IDX_GRP_B_LOCK_MUTE;
   endsequence

   a_reset_defaults: assert property (@(posedge clk)
      reset |=> muteBits_q == 8'h00 && rampDis_q == 2'b00 && lockFlag_q == 8'h00)
      else $error("reset left control bits set");

   a_mute_write: assert property (@(posedge clk) disable iff (reset)
      s_write_grp_a |=> muteBits_q[3:0] == $past(pwdata[3:0]))
      else $error("mute write not stored");

   a_absent_writes: assert property (@(posedge clk) disable iff (reset)
      !convPresent |=> $stable(muteBits_q) && $stable(rampDis_q))
      else $error("write took effect without converters");

   a_read_layout: assert property (@(posedge clk) disable iff (reset)
      s_read_setup_grp_a |=> prdata[15:0] == {4'h0, $past(lockFlag_q[3:0]), 4'h0, $past(muteBits_q[3:0])})
      else $error("group A read layout wrong");

   a_irq_set_wins: assert property (@(posedge clk) disable iff (reset)
      (|lockEvent) |=> (irqStat_q & $past(lockEvent)) == $past(lockEvent))
      else $error("lock event lost from status");

   a_mute_write_b: assert property (@(posedge clk) disable iff (reset)
      s_write_grp_b |=> muteBits_q[7:4] == $past(pwdata[3:0]))
      else $error("group B mute write not stored");

   a_read_layout_b: assert property (@(posedge clk) disable iff (reset)
      s_read_setup_grp_b |=> prdata[15:0] == {4'h0, $past(lockFlag_q[7:4]), 4'h0, $past(muteBits_q[7:4])})
      else $error("group B read layout wrong");

   a_upper_zero_a: assert property (@(posedge clk) disable iff (reset)
      s_read_setup_grp_a |=> prdata[31:16] == 16'h0000)
      else $error("group A upper bits not zero");

   a_upper_zero_b: assert property (@(posedge clk) disable iff (reset)
      s_read_setup_grp_b |=> prdata[31:16] == 16'h0000)
      else $error("group B upper bits not zero");

   a_ramp_dis_a: assert property (@(posedge clk) disable iff (reset)
      (psel && penable && pwrite && convPresent && regIdx == `ASRC_IDX_GRP_A_RAMP_DIS)
      |=> rampDis_q[0] == $past(pwdata[`ASRC_RAMP_DIS_BIT]))
      else $error("group A ramp disable not stored");

   a_ramp_dis_b: assert property (@(posedge clk) disable iff (reset)
      (psel && penable && pwrite && convPresent && regIdx == `ASRC_IDX_GRP_B_RAMP_DIS)
      |=> rampDis_q[1] == $past(pwdata[`ASRC_RAMP_DIS_BIT]))
      else $error("group B ramp disable not stored");

   a_unmapped_error: assert property (@(posedge clk) disable iff (reset)
      (setupPhase && !addrHit) |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

   a_irq_follows: assert property (@(posedge clk) disable iff (reset)
      (|(irqStat_q & irqMask_q)) |=> irq)
      else $error("interrupt not raised for unmasked status");

   a_status_clear: assert property (@(posedge clk) disable iff (reset)
      (psel && penable && pwrite && regIdx == `ASRC_IDX_IRQ_STATUS && lockEvent == 8'h00)
      |=> (irqStat_q & $past(pwdata[7:0])) == 8'h00)
      else $error("status bit not cleared by writing one");
endmodule
`default_nettype wire

// ---- testbench/routing_matrix_model.sv ----
// Routing matrix stand-in: output clocks, rate codes and sample strobes
`timescale 1ns/1ps
`default_nettype none
module routing_matrix_model (
   input wire logic clk, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic [7:0] lockReq, // Pairs given a valid output clock
   input wire logic [5:0] rateCode, // Rate code for every pair
   output logic [7:0] outClockLocked, // Output clock present per pair
   output logic [47:0] outRateSel, // Rate code per pair
   output logic [7:0] sampleTick // Output sample strobe
);
   logic [1:0] div_q;
   assign outRateSel = {8{rateCode}};
   // One sample every four clocks keeps a full ramp near 128 cycles
   always_ff @(posedge clk) begin
      div_q <= reset ? 2'h0 : div_q + 2'h1;
      outClockLocked <= reset ? 8'h00 : lockReq;
      sampleTick <= (!reset && div_q == 2'h3) ? 8'hFF : 8'h00;
   end
endmodule
`default_nettype wire

// ---- testbench/asrc_lock_mute_control_tb_top.sv ----
// Self-checking bench for the converter lock/mute control block
`timescale 1ns/1ps
`include "asrc_lmc_cfg.svh"
`default_nettype none
module asrc_lock_mute_control_tb_top;
   logic clk, reset, psel, penable, pwrite, convPresent, pready, pslverr, irq, err;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [7:0] mclkEnable, lockReq, outClockLocked, sampleTick, pairMuted, lockFlags;
   logic [47:0] outRateSel, pairGain;
   logic [5:0] rateCode;
   int mismatches, checks;
   logic [15:0] regs [6] = '{`ASRC_IDX_GRP_A_LOCK_MUTE, `ASRC_IDX_GRP_A_RAMP_DIS, `ASRC_IDX_GRP_B_LOCK_MUTE,
      `ASRC_IDX_GRP_B_RAMP_DIS, `ASRC_IDX_IRQ_STATUS, `ASRC_IDX_IRQ_MASK};
   asrc_lock_mute_control DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convPresent(convPresent), .mclkEnable(mclkEnable), .outClockLocked(outClockLocked),
      .outRateSel(outRateSel), .sampleTick(sampleTick), .pairGain(pairGain), .pairMuted(pairMuted),
      .lockFlags(lockFlags), .irq(irq));
   routing_matrix_model partner (.clk(clk), .reset(reset), .lockReq(lockReq), .rateCode(rateCode),
      .outClockLocked(outClockLocked), .outRateSel(outRateSel), .sampleTick(sampleTick));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [32:0] lockMuteWord(input logic [3:0] lock, input logic [3:0] mute);
      return {21'h0, lock, 4'h0, mute};
   endfunction
   task automatic chk(input string name, input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 33'h1, {32'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [32:0] e);
      apb(1'b0, idx, 32'h0);
      chk("prdata", e, {err, rd});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole run is near 2200 cycles
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, mclkEnable, lockReq} = '0;
      rateCode = 6'h3F;
      convPresent = 1'b1;
      reset = 1'b1;
      v = 32'h80B35996;
      cyc(3);
      reset <= 1'b0;
      foreach (regs[i]) rdchk(regs[i], 33'h0);
      chk("pairGain", {9'h0, {4{`ASRC_RAMP_STEPS}}}, {9'h0, pairGain[23:0]});
      chk("pairGain", {9'h0, {4{`ASRC_RAMP_STEPS}}}, {9'h0, pairGain[47:24]});
      rdchk(16'hE102, {1'b1, 32'h0});
      apb(1'b1, `ASRC_IDX_IRQ_MASK, 32'h0000000F);
      mclkEnable <= 8'hFF;
      cyc(3);
      chk("lockFlags", 33'hFF, {25'h0, lockFlags});
      rdchk(`ASRC_IDX_GRP_A_LOCK_MUTE, lockMuteWord(4'hF, 4'h0));
      rdchk(`ASRC_IDX_GRP_B_LOCK_MUTE, lockMuteWord(4'hF, 4'h0));
      cyc(200);
      chk("pairMuted", 33'hFF, {25'h0, pairMuted});
      chk("pairGain", 33'h0, {9'h0, pairGain[23:0]});
      chk("pairGain", 33'h0, {9'h0, pairGain[47:24]});
      lockReq <= 8'hFF;
      cyc(20);
      chk("lockFlags", 33'hFF, {25'h0, lockFlags});
      rateCode <= 6'h11;
      cyc(4);
      chk("lockFlags", 33'h0, {25'h0, lockFlags});
      chk("irq", 33'h1, {32'h0, irq});
      rdchk(`ASRC_IDX_IRQ_STATUS, 33'hFF);
      apb(1'b1, `ASRC_IDX_IRQ_STATUS, 32'h0000000F);
      cyc(3);
      chk("irq", 33'h0, {32'h0, irq});
      rdchk(`ASRC_IDX_IRQ_STATUS, 33'hF0);
      // Output clock loss, rate change and clock re-enable must not re-arm
      lockReq <= 8'h00;
      rateCode <= 6'h3F;
      mclkEnable <= 8'h00;
      cyc(3);
      mclkEnable <= 8'hFF;
      cyc(4);
      chk("lockFlags", 33'h0, {25'h0, lockFlags});
      repeat (6) begin
         v = lfsr(v);
         apb(1'b1, `ASRC_IDX_GRP_A_LOCK_MUTE, v);
         apb(1'b1, `ASRC_IDX_GRP_B_LOCK_MUTE, {v[15:0], v[31:16]});
         rdchk(`ASRC_IDX_GRP_A_LOCK_MUTE, lockMuteWord(4'h0, v[3:0]));
         cyc(200);
         chk("pairMuted", {25'h0, v[19:16], v[3:0]}, {25'h0, pairMuted});
      end
      // Mute reversed before the first step must return to unity, not overshoot
      apb(1'b1, `ASRC_IDX_GRP_A_LOCK_MUTE, 32'h00000000);
      cyc(200);
      apb(1'b1, `ASRC_IDX_GRP_A_LOCK_MUTE, 32'h0000000F);
      apb(1'b1, `ASRC_IDX_GRP_A_LOCK_MUTE, 32'h00000000);
      cyc(200);
      chk("pairGain", {9'h0, {4{`ASRC_RAMP_STEPS}}}, {9'h0, pairGain[23:0]});
      apb(1'b1, `ASRC_IDX_GRP_A_RAMP_DIS, 32'h0000FFFF);
      rdchk(`ASRC_IDX_GRP_A_RAMP_DIS, 33'h1);
      apb(1'b1, `ASRC_IDX_GRP_A_LOCK_MUTE, 32'h0000000F);
      apb(1'b1, `ASRC_IDX_GRP_B_LOCK_MUTE, 32'h0000000F);
      apb(1'b1, `ASRC_IDX_GRP_B_RAMP_DIS, 32'h00000000);
      cyc(200);
      chk("pairMuted", 33'hF0, {25'h0, pairMuted});
      reset <= 1'b1;
      mclkEnable <= 8'h00;
      cyc(2);
      reset <= 1'b0;
      rdchk(`ASRC_IDX_GRP_A_RAMP_DIS, 33'h0);
      apb(1'b1, `ASRC_IDX_GRP_A_RAMP_DIS, 32'h00000001);
      mclkEnable <= 8'hFF;
      cyc(6);
      chk("pairMuted", 33'h0F, {25'h0, pairMuted});
      convPresent <= 1'b0;
      apb(1'b1, `ASRC_IDX_GRP_B_LOCK_MUTE, 32'h0000000F);
      rdchk(`ASRC_IDX_GRP_B_LOCK_MUTE, lockMuteWord(4'hF, 4'h0));
      end_sim();
   end
endmodule
`default_nettype wire
